// File: logic/sbap_params.svh
`ifndef SBAP_PARAMS_SVH
`define SBAP_PARAMS_SVH

// sizes
`define SBAP_NI            14
`define SBAP_NT            13
`define SBAP_NR            14
`define SBAP_NG            4

// initiator roles (bit i = initiator i+1)
`define SBAP_ALWAYS_HIGH   4'hc
`define SBAP_CPU_MASK      14'h0003
`define SBAP_DMA_MASK      14'h003c
`define SBAP_SRAM_TGT      4'h0
`define SBAP_CONN          {14{13'h1fff}}

// register offsets
`define SBAP_OFF_CFG       12'h000
`define SBAP_OFF_UNLOCK    12'h004
`define SBAP_OFF_GRP       12'h008
`define SBAP_OFF_STATUS    12'h00c
`define SBAP_REGION_PAGE   6'h01

// system_config_reg fields
`define SBAP_BIT_DMA_PRI   25
`define SBAP_BIT_CPU_PRI   24
`define SBAP_BIT_LOCK      11

// region register fields
`define SBAP_RD_LSB        0
`define SBAP_WR_LSB        4

// reset values
`define SBAP_RST_PRI       1'b0
`define SBAP_RST_LOCK      1'b0
`define SBAP_RST_GROUP     2'h0
`define SBAP_RST_PERM      4'hf

// unlock keys (arbitrary values)
`define SBAP_KEY1          32'ha5a5_0f0f
`define SBAP_KEY2          32'h5a5a_f0f0

`endif

// File: logic/sbap_pkg.sv
`include "sbap_params.svh"

package sbap_pkg;

   typedef enum logic [1:0] {
      SBAP_UL_IDLE = 2'b00,
      SBAP_UL_KEY1 = 2'b01,
      SBAP_UL_OPEN = 2'b11
   } sbap_unlock_e;

   typedef struct packed {
      sbap_unlock_e state;
   } sbap_unlock_s;

   typedef logic [`SBAP_NI-1:0][`SBAP_NI-1:0] sbap_order_t;

   typedef struct packed {
      sbap_order_t order;
   } sbap_arb_s;

   typedef logic [`SBAP_NR-1:0][`SBAP_NG-1:0] sbap_perm_t;

   typedef struct packed {
      logic                         dma_pri;
      logic                         cpu_pri;
      logic                         lock;
      logic [`SBAP_NI-1:0][1:0]     grp;
      sbap_perm_t                   rd_perm;
      sbap_perm_t                   wr_perm;
      logic [`SBAP_NI-1:0]          grant;
      logic [`SBAP_NI-1:0]          deny;
      logic [`SBAP_NT-1:0]          busy;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
   } sbap_top_s;

endpackage : sbap_pkg

// File: logic/sbap_lrs_arb.sv
`include "sbap_params.svh"

module sbap_lrs_arb (
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   input  wire logic [`SBAP_NI-1:0] req_i,
   input  wire logic [`SBAP_NI-1:0] high_i,
   output logic      [`SBAP_NI-1:0] gnt_o
);

   function automatic sbap_pkg::sbap_order_t order_init();
      sbap_pkg::sbap_order_t o;
      for (int i = 0; i < `SBAP_NI; i++) begin
         for (int j = 0; j < `SBAP_NI; j++) begin
            o[i][j] = (i < j);
         end
      end
      return o;
   endfunction : order_init

   localparam sbap_pkg::sbap_order_t ORDER_RST = order_init();

   sbap_pkg::sbap_arb_s st;
   sbap_pkg::sbap_arb_s next_st;
   logic [`SBAP_NI-1:0] cand;
   logic [`SBAP_NI-1:0] gnt;

   always_comb begin
      logic win;
      win     = 1'b0;
      next_st = st;
      gnt     = '0;
      // ties in high class by order
      cand = (|(req_i & high_i)) ? (req_i & high_i) : req_i;
      for (int i = 0; i < `SBAP_NI; i++) begin
         win = cand[i];
         for (int j = 0; j < `SBAP_NI; j++) begin
            if (j != i && cand[j] && !st.order[i][j]) begin
               win = 1'b0;
            end
         end
         gnt[i] = win;
      end
      for (int i = 0; i < `SBAP_NI; i++) begin
         if (gnt[i]) begin
            for (int j = 0; j < `SBAP_NI; j++) begin
               next_st.order[i][j] = 1'b0;
               next_st.order[j][i] = (j != i);
            end
         end
      end
   end

   assign gnt_o = gnt;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st.order <= ORDER_RST;
      end else begin
         st <= next_st;
      end
   end

endmodule : sbap_lrs_arb

// File: logic/sbap_unlock.sv
`include "sbap_params.svh"

module sbap_unlock (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        key_wr_i,
   input  wire logic [31:0] key_i,
   input  wire logic        consume_i,
   output logic             open_o
);

   sbap_pkg::sbap_unlock_s st;
   sbap_pkg::sbap_unlock_s next_st;

   always_comb begin
      next_st = st;
      case (st.state)
         sbap_pkg::SBAP_UL_IDLE: begin
            if (key_wr_i && key_i == `SBAP_KEY1) begin
               next_st.state = sbap_pkg::SBAP_UL_KEY1;
            end
         end
         sbap_pkg::SBAP_UL_KEY1: begin
            if (key_wr_i) begin
               next_st.state = (key_i == `SBAP_KEY2) ? sbap_pkg::SBAP_UL_OPEN
                                                     : sbap_pkg::SBAP_UL_IDLE;
            end else if (consume_i) begin
               next_st.state = sbap_pkg::SBAP_UL_IDLE;
            end
         end
         sbap_pkg::SBAP_UL_OPEN: begin
            // any later key write or config write closes the window
            if (consume_i || key_wr_i) begin
               next_st.state = sbap_pkg::SBAP_UL_IDLE;
            end
         end
         default: begin
            next_st.state = sbap_pkg::SBAP_UL_IDLE;
         end
      endcase
   end

   assign open_o = (st.state == sbap_pkg::SBAP_UL_OPEN);

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st.state <= sbap_pkg::SBAP_UL_IDLE;
      end else begin
         st <= next_st;
      end
   end

endmodule : sbap_unlock

// File: logic/sbap_top.sv
// What this block does
// - initiators aiming at different targets are all granted in the same cycle.
// - contention for one target ends with exactly one grant per cycle.
// - least-recently-served ordering is the fixed default with no software control.
// - a high-priority requester beats every least-recently-served requester.
// - fourteen initiators; number 13 always high, 7-12 and 14 never, 1-6 selectable.
// - system_config_reg bit 25 makes DMA accesses to SRAM high priority.
// - system_config_reg bit 24 makes CPU accesses to SRAM high priority while the exception flag is 1.
// - up to thirteen targets, each initiator reaching only its connected ones.
// - fourteen regions, access allowed or refused by the initiator's permission group.
// - four independent groups 0 to 3, each with its own rights per region.
// - with permission_lock set, writes to group and region registers are dropped.
// - permission_lock changes only right after the unlock key sequence.
//
// Added by the designer: the register offsets and register access over APB.
`include "sbap_params.svh"

module sbap_top (
   input  wire logic                  clk_i,
   input  wire logic                  reset_n_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [11:0]           paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire logic [`SBAP_NI-1:0]   init_req_i,
   input  wire logic [`SBAP_NI-1:0]   init_write_i,
   input  wire logic [4*`SBAP_NI-1:0] init_target_i,
   input  wire logic [4*`SBAP_NI-1:0] init_region_i,
   input  wire logic                  exception_level_flag_i,
   output logic      [`SBAP_NI-1:0]   init_grant_o,
   output logic      [`SBAP_NI-1:0]   init_deny_o,
   output logic                       permission_lock_o
);

   localparam logic [`SBAP_NI-1:0][`SBAP_NT-1:0] CONN = `SBAP_CONN;

   sbap_pkg::sbap_top_s st;
   sbap_pkg::sbap_top_s next_st;

   logic [`SBAP_NI-1:0]                eff_req;
   logic [`SBAP_NI-1:0]                ok;
   logic [`SBAP_NI-1:0]                high;
   logic [`SBAP_NT-1:0][`SBAP_NI-1:0]  treq;
   logic [`SBAP_NT-1:0][`SBAP_NI-1:0]  tgnt;
   logic                               setup;
   logic                               wr_fire;
   logic                               key_wr;
   logic                               cfg_wr;
   logic                               ul_open;

   function automatic logic [3:0] field4(input logic [4*`SBAP_NI-1:0] v, input int i);
      return v[4*i +: 4];
   endfunction : field4

   function automatic logic region_hit(input logic [11:0] a);
      return a[11:6] == `SBAP_REGION_PAGE && a[5:2] < 4'(`SBAP_NR) && a[1:0] == 2'b00;
   endfunction : region_hit

   function automatic logic addr_ok(input logic [11:0] a);
      return a == `SBAP_OFF_CFG || a == `SBAP_OFF_UNLOCK || a == `SBAP_OFF_GRP
          || a == `SBAP_OFF_STATUS || region_hit(a);
   endfunction : addr_ok

   function automatic logic [31:0] rd_word(input logic [11:0] a,
                                           input sbap_pkg::sbap_top_s s);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == `SBAP_OFF_CFG) begin
         d[`SBAP_BIT_DMA_PRI] = s.dma_pri;
         d[`SBAP_BIT_CPU_PRI] = s.cpu_pri;
         d[`SBAP_BIT_LOCK]    = s.lock;
      end else if (a == `SBAP_OFF_GRP) begin
         d[2*`SBAP_NI-1:0] = s.grp;
      end else if (a == `SBAP_OFF_STATUS) begin
         d[`SBAP_NT-1:0] = s.busy;
      end else if (region_hit(a)) begin
         d[`SBAP_RD_LSB +: `SBAP_NG] = s.rd_perm[a[5:2]];
         d[`SBAP_WR_LSB +: `SBAP_NG] = s.wr_perm[a[5:2]];
      end
      return d;
   endfunction : rd_word

   assign setup   = psel_i & ~penable_i;
   assign wr_fire = psel_i & penable_i & st.pready & pwrite_i;
   assign key_wr  = wr_fire && paddr_i == `SBAP_OFF_UNLOCK;
   assign cfg_wr  = wr_fire && paddr_i == `SBAP_OFF_CFG;

   sbap_unlock u_unlock (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .key_wr_i  (key_wr),
      .key_i     (pwdata_i),
      .consume_i (cfg_wr),
      .open_o    (ul_open)
   );

   // per-initiator decode: reach, permission and priority class
   always_comb begin
      logic [3:0] tg;
      logic [3:0] rg;
      logic [1:0] g;
      tg   = 4'h0;
      rg   = 4'h0;
      g    = 2'h0;
      treq = '0;
      // a request already answered last cycle counts as taken
      eff_req = init_req_i & ~st.grant & ~st.deny;
      for (int i = 0; i < `SBAP_NI; i++) begin
         tg = field4(init_target_i, i);
         rg = field4(init_region_i, i);
         g  = st.grp[i];
         ok[i] = tg < 4'(`SBAP_NT) && CONN[i][tg] && rg < 4'(`SBAP_NR)
              && (init_write_i[i] ? st.wr_perm[rg][g] : st.rd_perm[rg][g]);
         high[i] = (i == `SBAP_ALWAYS_HIGH)
                || (`SBAP_CPU_MASK >> i & 14'h0001) != 14'h0000 && st.cpu_pri
                   && exception_level_flag_i && tg == `SBAP_SRAM_TGT
                || (`SBAP_DMA_MASK >> i & 14'h0001) != 14'h0000 && st.dma_pri
                   && tg == `SBAP_SRAM_TGT;
         for (int t = 0; t < `SBAP_NT; t++) begin
            treq[t][i] = eff_req[i] && ok[i] && tg == 4'(t);
         end
      end
   end

   // one arbiter per target, all in parallel
   for (genvar t = 0; t < `SBAP_NT; t++) begin : g_tgt
      sbap_lrs_arb u_arb (
         .clk_i     (clk_i),
         .reset_n_i (reset_n_i),
         .req_i     (treq[t]),
         .high_i    (high),
         .gnt_o     (tgnt[t])
      );
   end

   always_comb begin
      next_st = st;
      next_st.grant = '0;
      for (int t = 0; t < `SBAP_NT; t++) begin
         next_st.grant   = next_st.grant | tgnt[t];
         next_st.busy[t] = |tgnt[t];
      end
      next_st.deny = eff_req & ~ok;
      // bus answer: one access cycle, data prepared in setup
      next_st.pready  = setup;
      next_st.pslverr = setup && !addr_ok(paddr_i);
      next_st.prdata  = (setup && !pwrite_i) ? rd_word(paddr_i, st) : 32'h0000_0000;
      if (cfg_wr) begin
         next_st.dma_pri = pwdata_i[`SBAP_BIT_DMA_PRI];
         next_st.cpu_pri = pwdata_i[`SBAP_BIT_CPU_PRI];
         if (ul_open) begin
            next_st.lock = pwdata_i[`SBAP_BIT_LOCK];
         end
      end
      if (wr_fire && !st.lock && paddr_i == `SBAP_OFF_GRP) begin
         next_st.grp = pwdata_i[2*`SBAP_NI-1:0];
      end
      if (wr_fire && !st.lock && region_hit(paddr_i)) begin
         next_st.rd_perm[paddr_i[5:2]] = pwdata_i[`SBAP_RD_LSB +: `SBAP_NG];
         next_st.wr_perm[paddr_i[5:2]] = pwdata_i[`SBAP_WR_LSB +: `SBAP_NG];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st.dma_pri <= `SBAP_RST_PRI;
         st.cpu_pri <= `SBAP_RST_PRI;
         st.lock    <= `SBAP_RST_LOCK;
         st.grp     <= {`SBAP_NI{`SBAP_RST_GROUP}};
         st.rd_perm <= {`SBAP_NR{`SBAP_RST_PERM}};
         st.wr_perm <= {`SBAP_NR{`SBAP_RST_PERM}};
         st.grant   <= '0;
         st.deny    <= '0;
         st.busy    <= '0;
         st.prdata  <= 32'h0000_0000;
         st.pready  <= 1'b0;
         st.pslverr <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o          = st.prdata;
   assign pready_o          = st.pready;
   assign pslverr_o         = st.pslverr;
   assign init_grant_o      = st.grant;
   assign init_deny_o       = st.deny;
   assign permission_lock_o = st.lock;

endmodule : sbap_top

// File: verif/sbap_top_props.sv
`include "sbap_params.svh"

module sbap_top_props (
   input wire logic                  clk_i,
   input wire logic                  reset_n_i,
   input wire logic                  psel_i,
   input wire logic                  penable_i,
   input wire logic                  pwrite_i,
   input wire logic [11:0]           paddr_i,
   input wire logic [31:0]           pwdata_i,
   input wire logic [31:0]           prdata_o,
   input wire logic                  pready_o,
   input wire logic                  pslverr_o,
   input wire logic [`SBAP_NI-1:0]   init_req_i,
   input wire logic [4*`SBAP_NI-1:0] init_target_i,
   input wire logic [`SBAP_NI-1:0]   init_grant_o,
   input wire logic [`SBAP_NI-1:0]   init_deny_o,
   input wire logic                  permission_lock_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic cfg_wr;
   logic lock_bit;
   assign cfg_wr   = psel_i && penable_i && pwrite_i && paddr_i == `SBAP_OFF_CFG;
   assign lock_bit = pwdata_i[`SBAP_BIT_LOCK];

   function automatic logic mapped(logic [11:0] a);
      return a[1:0] == 2'h0 && (a < 12'h010 || (a >= 12'h040 && a < 12'h078));
   endfunction : mapped

   // pairwise scan, fine for fourteen initiators
   function automatic logic clash(logic [13:0] g, logic [55:0] t);
      logic c;
      c = 1'b0;
      for (int i = 0; i < 14; i++)
         for (int j = i + 1; j < 14; j++)
            c |= g[i] && g[j] && t[4*i+:4] == t[4*j+:4];
      return c;
   endfunction : clash

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence

   chk_ready_next: assert property (s_setup |=> s_answer)
      else $error("ready not a single cycle after setup");
   chk_unmapped_err: assert property (s_setup ##0 !mapped(paddr_i) |=> pslverr_o)
      else $error("unmapped access without error");
   chk_mapped_ok: assert property (s_setup ##0 mapped(paddr_i) |=> !pslverr_o)
      else $error("mapped access flagged as error");
   chk_idle_quiet: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
      else $error("read data or error outside access");
   chk_one_per_tgt: assert property (!clash(init_grant_o, $past(init_target_i)))
      else $error("two grants for one target");
   chk_answer_cause: assert property (((init_grant_o | init_deny_o) & ~$past(init_req_i)) == 0)
      else $error("answer without request");
   chk_grant_excl: assert property ((init_grant_o & init_deny_o) == 0)
      else $error("grant and deny together");
   chk_grant_pulse: assert property ((init_grant_o & $past(init_grant_o)) == 0)
      else $error("grant longer than one cycle");
   chk_lock_write: assert property ($changed(permission_lock_o) |-> $past(cfg_wr)
      && permission_lock_o == $past(lock_bit))
      else $error("lock changed without config write");
endmodule : sbap_top_props

// File: verif/sbap_init_model.sv
`include "sbap_params.svh"

module sbap_init_model (
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   input  wire logic [`SBAP_NI-1:0] start_i,
   input  wire logic [`SBAP_NI-1:0] grant_i,
   input  wire logic [`SBAP_NI-1:0] deny_i,
   output logic      [`SBAP_NI-1:0] req_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // held until answered, dropped at the answer edge so no re-request
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         req_o <= '0;
      end else begin
         req_o <= (req_o | start_i) & ~(grant_i | deny_i);
      end
   end
endmodule : sbap_init_model

// File: verif/sbap_top_tb_top.sv
`include "sbap_params.svh"

module sbap_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i     = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        psel_i    = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i  = 1'b0;
   logic [11:0] paddr_i   = 12'h0;
   logic [31:0] pwdata_i  = 32'h0;
   logic [13:0] start     = 14'h0;
   logic [13:0] wrq       = 14'h0;
   logic [55:0] tgt       = 56'h0;
   logic [55:0] rgn       = 56'h0;
   logic        exc       = 1'b0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic [13:0] req;
   logic [13:0] grant;
   logic [13:0] deny;
   logic        lock;
   int          error_cnt  = 0;
   int          n_compared = 0;

   always #12.5 clk_i = ~clk_i;

   sbap_top u_sbap_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .init_req_i(req),
      .init_write_i(wrq), .init_target_i(tgt), .init_region_i(rgn),
      .exception_level_flag_i(exc), .init_grant_o(grant), .init_deny_o(deny),
      .permission_lock_o(lock));
   sbap_init_model u_sbap_init_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start),
      .grant_i(grant), .deny_i(deny), .req_o(req));

   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // entered just after an edge; an idle cycle follows each transfer
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // no wait length assumed: only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check($sformatf("data %h", a), q, exp);
      check($sformatf("error %h", a), {31'h0, e}, {31'h0, err});
   endtask : rd

   // first answer compared as {deny, grant}, then every requester must be answered
   task automatic arb(input logic [13:0] m, input logic [55:0] t, input logic [27:0] exp);
      int n;
      n = 0;
      tgt   <= t;
      start <= m;
      @(posedge clk_i);
      start <= 14'h0;
      do begin
         @(posedge clk_i);
         n++;
      end while ((grant | deny) == 14'h0 && n < 20);
      check("first answer", {4'h0, deny, grant}, {4'h0, exp});
      n = 0;
      while (req != 14'h0 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      check("pending", {18'h0, req}, 32'h0);
      @(posedge clk_i);
   endtask : arb

   initial begin
      #300us;
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(`SBAP_OFF_CFG, 32'h0, 1'b0);
      rd(`SBAP_OFF_GRP, 32'h0, 1'b0);
      rd(12'h040, 32'h0000_00ff, 1'b0);
      rd(12'h020, 32'h0, 1'b1);
      rd(`SBAP_OFF_STATUS, 32'h0, 1'b0);
      rd(`SBAP_OFF_UNLOCK, 32'h0, 1'b0);
      arb(14'h0600, {14{4'h4}} ^ (56'h7 << 36), 28'h0600);
      arb(14'h00c0, {14{4'h1}}, 28'h0040);
      arb(14'h0180, {14{4'h1}}, 28'h0100);
      arb(14'h1001, {14{4'h2}}, 28'h1000);
      wr(`SBAP_OFF_CFG, 32'h0200_0000);
      arb(14'h0006, {14{4'h0}}, 28'h0004);
      arb(14'h1004, {14{4'h0}}, 28'h1000);
      wr(`SBAP_OFF_CFG, 32'h0100_0000);
      exc <= 1'b1;
      arb(14'h0012, {14{4'h0}}, 28'h0002);
      wr(`SBAP_OFF_GRP, 32'h00e0_0000);
      wr(12'h054, 32'h0000_003b);
      rgn <= {14{4'h5}};
      arb(14'h0400, {14{4'h6}}, {14'h0400, 14'h0});
      arb(14'h0200, {14{4'h6}}, 28'h0200);
      // group 3 may read region 5 but not write it
      wrq <= 14'h0800;
      arb(14'h0800, {14{4'h6}}, {14'h0800, 14'h0});
      wrq <= 14'h0000;
      arb(14'h0800, {14{4'h6}}, 28'h0800);
      wr(`SBAP_OFF_CFG, 32'h0000_0800);
      rd(`SBAP_OFF_CFG, 32'h0, 1'b0);
      wr(`SBAP_OFF_UNLOCK, `SBAP_KEY1);
      wr(`SBAP_OFF_UNLOCK, `SBAP_KEY2);
      wr(`SBAP_OFF_CFG, 32'h0000_0800);
      check("lock", {31'h0, lock}, 32'h1);
      // wrong second key closes the window
      wr(`SBAP_OFF_UNLOCK, `SBAP_KEY1);
      wr(`SBAP_OFF_UNLOCK, 32'h0000_0000);
      wr(`SBAP_OFF_CFG, 32'h0000_0000);
      check("lock kept", {31'h0, lock}, 32'h1);
      wr(12'h054, 32'h0000_00ff);
      wr(`SBAP_OFF_GRP, 32'h0);
      rd(12'h054, 32'h0000_003b, 1'b0);
      rd(`SBAP_OFF_GRP, 32'h00e0_0000, 1'b0);
      arb(14'h0400, {14{4'h6}}, {14'h0400, 14'h0});
      print_verdict();
   end
endmodule : sbap_top_tb_top

bind sbap_top sbap_top_props u_sbap_top_props (.*);
